// [shared/hecr_defs.vh]
`ifndef HECR_DEFS_VH
`define HECR_DEFS_VH

// System register selectors
`define HECR_SEL_W              2
`define HECR_SEL_DBGEVT         2'h0
`define HECR_SEL_RETPC          2'h1
`define HECR_SEL_SAVSTAT        2'h2
`define HECR_SEL_HYPSTAT        2'h3

// Debug event-enable layout
`define HECR_DEE_HOST_BIT       8
`define HECR_DEE_WMASK          32'h0000_01FF
`define HECR_DEE_RESET          32'h0000_0000

// Saved status layout
`define HECR_SS_UM_BIT          30
`define HECR_SS_MASK_HI         25
`define HECR_SS_MASK_LO         20
`define HECR_SS_CU_MSB_BIT      18
`define HECR_SS_WMASK           32'h43F7_80FF
`define HECR_SS_RESET           32'h0000_0020

// Hypervisor status word layout
`define HECR_HS_GM_BIT          31
`define HECR_HS_PID_HI          10
`define HECR_HS_PID_LO          8

`endif

// [verilog/hecr_top.v]
`timescale 1ns/10ps
`include "hecr_defs.vh"

// What this block does
// - Enable register gates breakpoint events when enabled
// - Disabled: contents kept, no event influence
// - Load/store access needs no debug privilege
// - Bit 8 allows host mode events
// - Bits 7..0 allow events per partition
// - Host context registers exist only when enabled
// - Host registers use original privilege checks
// - Acknowledge saves interrupted or next PC
// - Return forces loaded PC bit 0 low
// - Acknowledge copies host status into save
// - Saved status field layout fixed
// - Reset: bit 5 set, others zero
// - Priority mask zero unless extended levels
// - Top coprocessor bit always reads zero
// - Guest flag bit 31, zero when disabled
// - Partition id bits 10..8, zero when disabled
module hecr_top #(
    parameter PID_W = 3
) (
    input  wire                   REF_CLK_IN,
    input  wire                   RST_N_IN,
    input  wire                   HYP_ENABLE_IN,
    input  wire                   GUEST_MODE_IN,
    input  wire [PID_W-1:0]       PARTITION_ID_IN,
    input  wire                   EXT_PRIO_LEVELS_IN,
    input  wire                   PRIV_OK_IN,
    input  wire                   SR_WR_IN,
    input  wire                   SR_RD_IN,
    input  wire [`HECR_SEL_W-1:0] SR_SEL_IN,
    input  wire [31:0]            SR_WDATA_IN,
    input  wire                   EXC_ACK_IN,
    input  wire [31:0]            EXC_PC_IN,
    input  wire [31:0]            HOST_STATUS_IN,
    output reg  [31:0]            SR_RDATA_OUT,
    output wire                   SR_UNDEF_OUT,
    output wire                   SR_PRIV_ERR_OUT,
    output wire [31:0]            RETURN_PC_OUT,
    output wire [31:0]            RESTORE_STATUS_OUT,
    output wire                   BRK_EVENT_ALLOW_OUT
);

    localparam GUEST_N = 1 << PID_W;

    reg  [31:0]        debug_event_enable_reg;
    reg  [31:0]        debug_event_enable_next;
    reg  [31:0]        host_maskable_return_pc_reg;
    reg  [31:0]        host_maskable_return_pc_next;
    reg  [31:0]        host_maskable_saved_status_reg;
    reg  [31:0]        host_maskable_saved_status_next;
    reg  [31:0]        rdata_next;
    reg                brk_allow_next;
    wire               sel_dbgevt;
    wire               sel_retpc;
    wire               sel_savstat;
    wire               sel_hypstat;
    wire               host_sel;
    wire               sel_undef;
    wire               access;
    wire               wr_ok;
    wire               wr_dbgevt;
    wire               wr_retpc;
    wire               wr_savstat;
    wire               save_host;
    wire [31:0]        status_wdata;
    wire [31:0]        status_save;
    wire [31:0]        hyper_status_word;
    wire               guest_mode_flag;
    wire [PID_W-1:0]   partition_id;
    wire               host_event_allow;
    wire [GUEST_N-1:0] guest_part_event_allow;
    wire [GUEST_N-1:0] guest_hit;
    wire               guest_event_allow;

    // Selector decode
    assign sel_dbgevt  = (SR_SEL_IN == `HECR_SEL_DBGEVT);
    assign sel_retpc   = (SR_SEL_IN == `HECR_SEL_RETPC);
    assign sel_savstat = (SR_SEL_IN == `HECR_SEL_SAVSTAT);
    assign sel_hypstat = (SR_SEL_IN == `HECR_SEL_HYPSTAT);
    assign host_sel    = sel_retpc || sel_savstat;
    assign access      = SR_WR_IN || SR_RD_IN;

    // Host context only exists with virtualization on
    assign sel_undef       = !HYP_ENABLE_IN && (host_sel || sel_dbgevt);
    assign SR_UNDEF_OUT    = access && sel_undef;
    // Debug enables skip privilege; host copies inherit the caller's check
    assign SR_PRIV_ERR_OUT = SR_WR_IN && host_sel && HYP_ENABLE_IN && !PRIV_OK_IN;
    assign wr_ok           = SR_WR_IN && !sel_undef;
    assign wr_dbgevt       = wr_ok && sel_dbgevt;
    assign wr_retpc        = wr_ok && sel_retpc && PRIV_OK_IN;
    assign wr_savstat      = wr_ok && sel_savstat && PRIV_OK_IN;

    // Priority mask only holds nonzero with extended levels; CU top bit tied low
    function [31:0] fix_status;
        input [31:0] v;
        input        extended_priority_levels;
        begin
            fix_status = v & `HECR_SS_WMASK;
            fix_status[`HECR_SS_CU_MSB_BIT] = 1'b0;
            if (!extended_priority_levels) begin
                fix_status[`HECR_SS_MASK_HI:`HECR_SS_MASK_LO] = 6'h00;
            end
        end
    endfunction

    assign save_host    = EXC_ACK_IN && HYP_ENABLE_IN && !GUEST_MODE_IN;
    assign status_wdata = fix_status(SR_WDATA_IN, EXT_PRIO_LEVELS_IN);
    assign status_save  = fix_status(HOST_STATUS_IN, EXT_PRIO_LEVELS_IN);

    // Mode and partition read as zero when virtualization is off
    assign guest_mode_flag   = HYP_ENABLE_IN && GUEST_MODE_IN;
    assign partition_id      = HYP_ENABLE_IN ? PARTITION_ID_IN : {PID_W{1'b0}};
    assign hyper_status_word = {guest_mode_flag, 20'h0_0000, partition_id, 8'h00};

    // Disabling does not clear the enables; they just stop acting
    always @* begin
        debug_event_enable_next = debug_event_enable_reg;
        if (wr_dbgevt) begin
            debug_event_enable_next = SR_WDATA_IN & `HECR_DEE_WMASK;
        end
    end

    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            debug_event_enable_reg <= `HECR_DEE_RESET;
        end else begin
            debug_event_enable_reg <= debug_event_enable_next;
        end
    end

    // Exception save wins over a same-cycle software write
    always @* begin
        host_maskable_return_pc_next = host_maskable_return_pc_reg;
        if (save_host) begin
            host_maskable_return_pc_next = EXC_PC_IN;
        end else if (wr_retpc) begin
            host_maskable_return_pc_next = SR_WDATA_IN;
        end
    end

    always @* begin
        host_maskable_saved_status_next = host_maskable_saved_status_reg;
        if (save_host) begin
            host_maskable_saved_status_next = status_save;
        end else if (wr_savstat) begin
            host_maskable_saved_status_next = status_wdata;
        end else if (!EXT_PRIO_LEVELS_IN) begin
            host_maskable_saved_status_next[`HECR_SS_MASK_HI:`HECR_SS_MASK_LO] = 6'h00;
        end
    end

    // One process so the pair can never split
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            host_maskable_return_pc_reg    <= 32'h0000_0000;
            host_maskable_saved_status_reg <= `HECR_SS_RESET;
        end else begin
            host_maskable_return_pc_reg    <= host_maskable_return_pc_next;
            host_maskable_saved_status_reg <= host_maskable_saved_status_next;
        end
    end

    // One compare per partition keeps the select shallow
    genvar g;
    generate
        for (g = 0; g < GUEST_N; g = g + 1) begin : g_guest
            localparam [PID_W-1:0] PID_G = g;
            assign guest_hit[g] = guest_part_event_allow[g] && (PARTITION_ID_IN == PID_G);
        end
    endgenerate

    assign host_event_allow       = debug_event_enable_reg[`HECR_DEE_HOST_BIT];
    assign guest_part_event_allow = debug_event_enable_reg[GUEST_N-1:0];
    assign guest_event_allow      = |guest_hit;

    // Off: always allow, the enables have no say
    always @* begin
        brk_allow_next = 1'b1;
        if (HYP_ENABLE_IN) begin
            if (GUEST_MODE_IN) begin
                brk_allow_next = guest_event_allow;
            end else begin
                brk_allow_next = host_event_allow;
            end
        end
    end

    always @* begin
        rdata_next = 32'h0000_0000;
        if (sel_undef) begin
            rdata_next = 32'h0000_0000;
        end else if (sel_dbgevt) begin
            rdata_next = debug_event_enable_reg;
        end else if (sel_retpc) begin
            rdata_next = host_maskable_return_pc_reg;
        end else if (sel_savstat) begin
            rdata_next = host_maskable_saved_status_reg;
        end else if (sel_hypstat) begin
            rdata_next = hyper_status_word;
        end
    end

    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SR_RDATA_OUT <= 32'h0000_0000;
        end else if (SR_RD_IN) begin
            SR_RDATA_OUT <= rdata_next;
        end
    end

    // Stored bit 0 may be 1; the fetch path never sees it
    assign RETURN_PC_OUT      = {host_maskable_return_pc_reg[31:1], 1'b0};
    assign RESTORE_STATUS_OUT = host_maskable_saved_status_reg;

    assign BRK_EVENT_ALLOW_OUT = brk_allow_next;

endmodule // hecr_top

// [sim/hecr_asserts.sv]
`timescale 1ns/10ps
module hecr_asserts #(parameter PID_W = 3) (
    input wire             REF_CLK_IN, RST_N_IN, HYP_ENABLE_IN, GUEST_MODE_IN, EXT_PRIO_LEVELS_IN, PRIV_OK_IN,
    input wire             SR_WR_IN, SR_RD_IN, EXC_ACK_IN, SR_UNDEF_OUT, SR_PRIV_ERR_OUT, BRK_EVENT_ALLOW_OUT,
    input wire [PID_W-1:0] PARTITION_ID_IN,
    input wire [1:0]       SR_SEL_IN,
    input wire [31:0]      SR_WDATA_IN, EXC_PC_IN, HOST_STATUS_IN, SR_RDATA_OUT, RETURN_PC_OUT, RESTORE_STATUS_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire dw = SR_WR_IN && SR_SEL_IN == 2'h0 && HYP_ENABLE_IN;
    property p_host; dw ##1 HYP_ENABLE_IN && !GUEST_MODE_IN |-> BRK_EVENT_ALLOW_OUT == $past(SR_WDATA_IN[8]); endproperty
    a_host: assert property (p_host) else $error("host allow wrong");
    property p_guest; dw ##1 HYP_ENABLE_IN && GUEST_MODE_IN && $stable(PARTITION_ID_IN)
        |-> BRK_EVENT_ALLOW_OUT == $past(SR_WDATA_IN[PARTITION_ID_IN]); endproperty
    a_guest: assert property (p_guest) else $error("guest allow wrong");
    property p_off; !HYP_ENABLE_IN |-> BRK_EVENT_ALLOW_OUT; endproperty
    a_off: assert property (p_off) else $error("allow gated while off");
    property p_undef; SR_UNDEF_OUT == (!HYP_ENABLE_IN && (SR_WR_IN || SR_RD_IN) && SR_SEL_IN != 2'h3); endproperty
    a_undef: assert property (p_undef) else $error("undefined flag wrong");
    property p_priv; SR_PRIV_ERR_OUT == (HYP_ENABLE_IN && SR_WR_IN && !PRIV_OK_IN && SR_SEL_IN inside {1, 2}); endproperty
    a_priv: assert property (p_priv) else $error("privilege flag wrong");
    property p_save; EXC_ACK_IN && HYP_ENABLE_IN && !GUEST_MODE_IN && EXT_PRIO_LEVELS_IN |=> RETURN_PC_OUT ==
        ($past(EXC_PC_IN) & 32'hFFFF_FFFE) && RESTORE_STATUS_OUT == ($past(HOST_STATUS_IN) & 32'h43F3_80FF); endproperty
    a_save: assert property (p_save) else $error("save pair wrong");
    property p_epl; !EXT_PRIO_LEVELS_IN |=> RESTORE_STATUS_OUT[25:20] == 6'h00; endproperty
    a_epl: assert property (p_epl) else $error("mask field not cleared");
    property p_resv; (RESTORE_STATUS_OUT & 32'hBC0C_7F00) == 32'h0000_0000 && !RETURN_PC_OUT[0]; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_hs; SR_RD_IN && SR_SEL_IN == 2'h3 |=> SR_RDATA_OUT == ($past(HYP_ENABLE_IN) ?
        {$past(GUEST_MODE_IN), 20'h0_0000, $past(PARTITION_ID_IN), 8'h00} : 32'h0000_0000); endproperty
    a_hs: assert property (p_hs) else $error("status word read wrong");
endmodule // hecr_asserts
bind hecr_top hecr_asserts #(.PID_W(PID_W)) u_asserts (.*);

// [sim/test_hecr_top.sv]
`timescale 1ns/10ps
module test_hecr_top;
    reg         clk = 0, rst_n = 0, hypervisor_enable = 1, gm = 0, extended_priority_levels = 1, pok = 1, wr = 0, rd = 0, ack = 0, u, pe;
    reg  [2:0]  pid = 0;
    reg  [1:0]  sel = 0;
    reg  [31:0] wd = 0, epc = 0, hst = 0;
    wire [31:0] rdat, rpc, rst_st;
    wire        undef, perr, allow;
    integer     fails = 0, comparisons = 0, cyc = 0, i;
    always #50 clk = ~clk;
    hecr_top u_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .HYP_ENABLE_IN(hypervisor_enable), .GUEST_MODE_IN(gm),
        .PARTITION_ID_IN(pid), .EXT_PRIO_LEVELS_IN(extended_priority_levels), .PRIV_OK_IN(pok), .SR_WR_IN(wr), .SR_RD_IN(rd),
        .SR_SEL_IN(sel), .SR_WDATA_IN(wd), .EXC_ACK_IN(ack), .EXC_PC_IN(epc), .HOST_STATUS_IN(hst),
        .SR_RDATA_OUT(rdat), .SR_UNDEF_OUT(undef), .SR_PRIV_ERR_OUT(perr), .RETURN_PC_OUT(rpc),
        .RESTORE_STATUS_OUT(rst_st), .BRK_EVENT_ALLOW_OUT(allow));
    task close_out;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, g);
        end
    endtask
    task cyc1; @(posedge clk); #10; endtask
    // Errors are combinational, so they are caught while the strobe stands
    task acc(input w, input [1:0] s, input [31:0] d);
        wr = w; rd = !w; sel = s; wd = d; #1 u = undef; pe = perr; cyc1; wr = 0; rd = 0; cyc1;
    endtask
    task exc(input [31:0] pc, input [31:0] st); ack = 1; epc = pc; hst = st; cyc1; ack = 0; cyc1; endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 500) begin
            fails = fails + 1;
            close_out;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #10 rst_n = 1;
        acc(0, 2, 0); chk("rst_status", 32'h0000_0020, rdat);
        acc(1, 0, 32'h0000_01FF); chk("host_on", 1, allow);
        acc(1, 0, 32'h0000_00FF); chk("host_off", 0, allow);
        gm = 1;
        for (i = 0; i < 8; i = i + 1) begin
            pid = i; acc(1, 0, 32'h0000_0001 << i); chk("guest_on", 1, allow);
            pid = i + 1; #1 chk("guest_off", 0, allow);
        end
        hypervisor_enable = 0; acc(0, 0, 0); chk("undef", 1, u);
        chk("off_allow", 1, allow);
        acc(0, 3, 0); chk("hs_off", 0, rdat);
        hypervisor_enable = 1; pid = 5; acc(0, 3, 0); chk("hs_on", 32'h8000_0500, rdat);
        pid = 7; acc(0, 0, 0); chk("kept", 32'h0000_0080, rdat);
        gm = 0; exc(32'h1234_5678, 32'hFFFF_FFFF); chk("pc", 32'h1234_5678, rpc);
        chk("st", 32'h43F3_80FF, rst_st);
        gm = 1; exc(0, 0); chk("guest_ack", 32'h1234_5678, rpc); gm = 0;
        extended_priority_levels = 0; cyc1; chk("epl", 32'h4003_80FF, rst_st); extended_priority_levels = 1;
        pok = 0; acc(1, 1, 32'h0000_0010); chk("perr", 1, pe); chk("nopc", 32'h1234_5678, rpc);
        pok = 1; acc(0, 1, 0); chk("nest_save", 32'h1234_5678, rdat);
        exc(32'h0000_2000, 0); chk("nest", 32'h0000_2000, rpc);
        acc(1, 1, 32'h1234_5678); chk("restore", 32'h1234_5678, rpc);
        acc(1, 1, 32'h0000_0011); chk("odd", 32'h0000_0010, rpc);
        acc(1, 2, 32'hFFFF_FFFF); acc(0, 2, 0); chk("st_rd", 32'h43F3_80FF, rdat);
        wr = 1; sel = 1; wd = 32'h0000_0044; ack = 1; epc = 32'h0000_0088; hst = 0; cyc1;
        wr = 0; ack = 0; cyc1; chk("win", 32'h0000_0088, rpc);
        close_out;
    end
endmodule // test_hecr_top
